// file: sdd_decim_top.sv
// Function
// RULE1 - Each channel takes a one-bit modulator sample once every eight device master clock ticks.
// RULE2 - Each decimator delivers one output word every 256 device master clock ticks.
// RULE3 - The decimator is three cascaded 32-tap unit-weight moving sums, a sinc-cubed response.
// RULE4 - Resolution grows from one bit to a 15-bit result word per channel.
// RULE5 - Output words are two's complement, negative inputs giving negative codes.
// RULE6 - In data mode the 15-bit result is shifted left one place with a zero least bit.
// RULE7 - At or above positive full scale the data mode word is 7FFF with its least bit set.
// RULE8 - In mixed mode a 15-bit sample is sent with the top frame bit used as the content flag.
// RULE9 - A 3-bit gain select per channel maps codes 0 to 7 onto 0, 6, 12, 18, 20, 26, 32, 38 dB.
// RULE10 - Six independent channel paths share the device master clock.
// RULE11 - Data mode is selected by config bit zero, mixed mode by bits zero and one together.
// RULE12 - The device master clock is the pin clock divided by a programmable ratio.
// RULE13 - All channel words are latched together once per decimation period as a sample event.
// RULE14 - Filter stages are wide enough to hold the full gain of 32768 without overflow.
`timescale 1ns/100ps
module sdd_decim_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [2:0] i_mclk_div_code,
	input wire logic i_cfg_data_sel,
	input wire logic i_cfg_mixed_sel,
	input wire logic [sdd_pkg::NCH-1:0][2:0] i_gain_sel,
	input wire logic [sdd_pkg::NCH-1:0] i_mod_bit,
	output logic o_mod_strobe,
	output logic [sdd_pkg::NCH-1:0][5:0] o_gain_db,
	output logic o_sample_event,
	output logic o_overrun,
	output logic o_sample_valid,
	input wire logic i_sample_ready,
	output sdd_pkg::sdd_sample_s o_sample
);
	localparam int NCH = sdd_pkg::NCH;
	localparam int W = sdd_pkg::CIC_W;

	logic [2:0] div_cnt_reg;
	logic [7:0] phase_reg;
	logic [NCH-1:0] sync1_reg;
	logic [NCH-1:0] sync2_reg;
	logic [NCH-1:0] sync3_reg;
	logic [NCH-1:0] stable_reg;
	logic mod_strobe_reg;
	logic sample_event_reg;
	logic overrun_reg;
	logic [NCH-1:0][5:0] gain_db_reg;
	sdd_pkg::sdd_sample_s word_reg [NCH];
	logic pend_reg;
	logic [2:0] push_idx_reg;
	logic [NCH-1:0] sat_pos;
	logic [NCH-1:0] neg_res;
	logic fifo_in_ready;

	wire [2:0] div_last = (i_mclk_div_code <= sdd_pkg::DIV_CODE_MAX) ? i_mclk_div_code : 3'h0;
	wire dm_tick = (div_cnt_reg >= div_last); // RULE12
	wire bit_tick = dm_tick && (phase_reg[2:0] == sdd_pkg::BIT_LAST); // RULE1
	wire out_event = dm_tick && (phase_reg == sdd_pkg::PHASE_LAST); // RULE2
	wire [NCH-1:0] stable_next = (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
	wire push_last = (push_idx_reg == 3'(NCH - 1));
	wire push_take = pend_reg && fifo_in_ready;
	sdd_pkg::sdd_mode_e mode;
	assign mode = !i_cfg_data_sel ? sdd_pkg::SDD_MODE_CTRL
		: i_cfg_mixed_sel ? sdd_pkg::SDD_MODE_MIXED : sdd_pkg::SDD_MODE_DATA; // RULE11

	assign o_mod_strobe = mod_strobe_reg;
	assign o_sample_event = sample_event_reg;
	assign o_overrun = overrun_reg;
	assign o_gain_db = gain_db_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			div_cnt_reg <= sdd_pkg::DIV_CNT_RST;
			phase_reg <= sdd_pkg::PHASE_RST;
			mod_strobe_reg <= 1'b0;
			sample_event_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			div_cnt_reg <= dm_tick ? sdd_pkg::DIV_CNT_RST : div_cnt_reg + 3'h1; // RULE12
			if (dm_tick)
				phase_reg <= phase_reg + 8'h01;
			mod_strobe_reg <= bit_tick; // RULE1
			sample_event_reg <= out_event; // RULE13
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			stable_reg <= '0;
		end
		else if (i_ce)
		begin
			sync1_reg <= i_mod_bit;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			stable_reg <= stable_next;
		end
	end

	for (genvar ch = 0; ch < NCH; ch++)
	begin : g_chan // RULE10
		logic signed [W-1:0] int1_reg;
		logic signed [W-1:0] int2_reg;
		logic signed [W-1:0] int3_reg;
		logic signed [W-1:0] dly1_reg;
		logic signed [W-1:0] dly2_reg;
		logic signed [W-1:0] dly3_reg;
		wire signed [W-1:0] x_in = stable_reg[ch] ? 18'sh00001 : -18'sh00001; // RULE5
		wire signed [W-1:0] comb1 = int3_reg - dly1_reg; // RULE3
		wire signed [W-1:0] comb2 = comb1 - dly2_reg;
		wire signed [W-1:0] comb3 = comb2 - dly3_reg;
		wire signed [W-1:0] half = comb3 >>> 1; // RULE4
		wire [sdd_pkg::RES_W-1:0] res15 = sat_pos[ch] ? sdd_pkg::RES_MAX : half[sdd_pkg::RES_W-1:0];
		wire [sdd_pkg::WORD_W-1:0] data_word = sat_pos[ch] ? sdd_pkg::SAT_WORD : {res15, 1'b0};
		wire [sdd_pkg::WORD_W-1:0] mixed_word = {sdd_pkg::DATA_FLAG, res15}; // RULE8
		assign sat_pos[ch] = !half[W-1] && (half[W-2:sdd_pkg::RES_W-1] != '0); // RULE7
		assign neg_res[ch] = half[W-1];

		always_ff @(posedge i_clk)
		begin
			if (i_rst)
			begin
				int1_reg <= sdd_pkg::CIC_RST;
				int2_reg <= sdd_pkg::CIC_RST;
				int3_reg <= sdd_pkg::CIC_RST;
				dly1_reg <= sdd_pkg::CIC_RST;
				dly2_reg <= sdd_pkg::CIC_RST;
				dly3_reg <= sdd_pkg::CIC_RST;
				word_reg[ch] <= '0;
				gain_db_reg[ch] <= sdd_pkg::GAIN_DB[0];
			end
			else if (i_ce)
			begin
				gain_db_reg[ch] <= sdd_pkg::GAIN_DB[i_gain_sel[ch]]; // RULE9
				if (bit_tick)
				begin
					int1_reg <= int1_reg + x_in; // RULE14
					int2_reg <= int2_reg + int1_reg;
					int3_reg <= int3_reg + int2_reg;
				end
				if (out_event)
				begin
					dly1_reg <= int3_reg;
					dly2_reg <= comb1;
					dly3_reg <= comb2;
					word_reg[ch].chan <= 3'(ch);
					word_reg[ch].word <= (mode == sdd_pkg::SDD_MODE_MIXED) ? mixed_word : data_word; // RULE6
				end
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			pend_reg <= 1'b0;
			push_idx_reg <= 3'h0;
			overrun_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			overrun_reg <= out_event && pend_reg && !(push_take && push_last);
			if (out_event && (mode != sdd_pkg::SDD_MODE_CTRL))
			begin
				pend_reg <= 1'b1; // RULE13
				push_idx_reg <= 3'h0;
			end
			else if (push_take)
			begin
				pend_reg <= !push_last;
				push_idx_reg <= push_last ? 3'h0 : push_idx_reg + 3'h1;
			end
		end
	end

	sdd_fifo #(
		.WIDTH($bits(sdd_pkg::sdd_sample_s)),
		.DEPTH(sdd_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_valid(pend_reg),
		.o_ready(fifo_in_ready),
		.i_data(word_reg[push_idx_reg]),
		.o_valid(o_sample_valid),
		.i_ready(i_sample_ready),
		.o_data(o_sample)
	);

	a_mod_strobe_pace: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		(i_ce && bit_tick) |=> (o_mod_strobe && phase_reg[2:0] == 3'h0))
		else $error("modulator strobe not after bit tick");

	a_event_on_bit: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
		o_sample_event |-> (o_mod_strobe && phase_reg == 8'h00))
		else $error("output event off the bit grid");

	a_event_latch: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
		(i_ce && out_event && mode != sdd_pkg::SDD_MODE_CTRL) |=> (o_sample_event && pend_reg
		&& push_idx_reg == 3'h0))
		else $error("sample event not raised");

	a_gain_map: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
		(i_ce && i_gain_sel[0] == 3'h4) |=> (o_gain_db[0] == 6'h14))
		else $error("gain code four not 20 dB");

	a_data_lsb_zero: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
		(i_ce && out_event && mode == sdd_pkg::SDD_MODE_DATA && !sat_pos[1])
		|=> (word_reg[1].word[0] == 1'b0))
		else $error("data word least bit not zero");

	a_data_saturate: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
		(i_ce && out_event && mode == sdd_pkg::SDD_MODE_DATA && sat_pos[2])
		|=> (word_reg[2].word == 16'h7FFF))
		else $error("full scale word not 7FFF");

	a_mixed_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		(i_ce && out_event && mode == sdd_pkg::SDD_MODE_MIXED) |=> (word_reg[3].word[15] == 1'b0))
		else $error("mixed word flag not data");

	a_sign_code: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
		(i_ce && out_event && mode == sdd_pkg::SDD_MODE_DATA && neg_res[4])
		|=> (word_reg[4].word[15] == 1'b1))
		else $error("negative result not negative code");

	a_push_stall: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
		(i_ce && pend_reg && !fifo_in_ready && !out_event) |=> (pend_reg
		&& push_idx_reg == $past(push_idx_reg)))
		else $error("push advanced while fifo full");

	a_div_ratio: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
		(i_ce && dm_tick && i_mclk_div_code == 3'h1 && $stable(i_mclk_div_code) && i_ce)
		|=> (!i_ce || !dm_tick))
		else $error("divide by two ticked twice");

	a_strobe_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		(i_ce && o_mod_strobe)
		|=> !o_mod_strobe)
		else $error("modulator strobe longer than one cycle");

	a_event_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
		(i_ce && o_sample_event)
		|=> !o_sample_event)
		else $error("sample event longer than one cycle");

	a_phase_step: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
		(i_ce && dm_tick)
		|=> (phase_reg == $past(phase_reg) + 8'h01))
		else $error("phase did not step on device tick");

	a_phase_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
		(i_ce && !dm_tick)
		|=> (phase_reg == $past(phase_reg)))
		else $error("phase moved between device ticks");

	a_div_count: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
		(i_ce && !dm_tick)
		|=> (div_cnt_reg == $past(div_cnt_reg) + 3'h1))
		else $error("divider count did not advance");

	a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
		!i_ce |=> (phase_reg == $past(phase_reg) && div_cnt_reg == $past(div_cnt_reg)
		&& o_sample_event == $past(o_sample_event)))
		else $error("state moved while clock enable low");

	a_overrun_cause: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
		(i_ce && out_event && pend_reg && !fifo_in_ready)
		|=> o_overrun)
		else $error("overrun not flagged");

	a_ctrl_no_push: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
		(i_ce && mode == sdd_pkg::SDD_MODE_CTRL && !pend_reg)
		|=> !pend_reg)
		else $error("control mode started a push");

	a_chan_order: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
		(i_ce && push_take && !out_event && !push_last)
		|=> (push_idx_reg == $past(push_idx_reg) + 3'h1))
		else $error("channel push order broken");

	a_gain_top: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
		(i_ce && i_gain_sel[5] == 3'h7)
		|=> (o_gain_db[5] == 6'h26))
		else $error("gain code seven not 38 dB");

	a_mixed_sat: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		(i_ce && out_event && mode == sdd_pkg::SDD_MODE_MIXED && sat_pos[0])
		|=> (word_reg[0].word == 16'h3FFF))
		else $error("mixed full scale word not 3FFF");

	a_valid_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
		(i_ce && o_sample_valid && !i_sample_ready)
		|=> (o_sample_valid && $stable(o_sample)))
		else $error("sample dropped while consumer stalled");

endmodule // sdd_decim_top

// file: sdd_pkg.sv
package sdd_pkg;

	localparam int NCH = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int CIC_W = 18;
	localparam int RES_W = 15;
	localparam int WORD_W = 16;
	localparam int BIT_DIV = 8;
	localparam int DEC_RATIO = 32;
	localparam int OUT_DIV = BIT_DIV * DEC_RATIO;
	localparam logic [2:0] BIT_LAST = 3'(BIT_DIV - 1);
	localparam logic [7:0] PHASE_LAST = 8'(OUT_DIV - 1);
	localparam logic [2:0] DIV_CODE_MAX = 3'h4;
	localparam logic [2:0] DIV_CNT_RST = 3'h0;
	localparam logic [7:0] PHASE_RST = 8'h00;
	localparam logic [CIC_W-1:0] CIC_RST = 18'h00000;
	localparam logic [RES_W-1:0] RES_MAX = 15'h3FFF;
	localparam logic [WORD_W-1:0] SAT_WORD = 16'h7FFF;
	localparam logic DATA_FLAG = 1'b0;
	localparam logic [5:0] GAIN_DB [8] = '{6'h00, 6'h06, 6'h0C, 6'h12, 6'h14, 6'h1A, 6'h20, 6'h26};

	typedef enum {SDD_MODE_CTRL, SDD_MODE_DATA, SDD_MODE_MIXED} sdd_mode_e;

	typedef struct packed
	{
		logic [2:0] chan;
		logic [WORD_W-1:0] word;
	} sdd_sample_s;

endpackage

// file: sdd_fifo.sv
`timescale 1ns/100ps
module sdd_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	wire empty = (wr_ptr_reg == rd_ptr_reg);
	wire do_wr = i_ce && i_valid && !full;
	wire do_rd = i_ce && !empty && (!out_valid_reg || i_ready);

	assign o_ready = !full;
	assign o_valid = out_valid_reg;
	assign o_data = out_data_reg;

	always_ff @(posedge i_clk)
	begin
		if (do_wr)
		begin
			mem[wr_ptr_reg[AW-1:0]] <= i_data;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end
		else if (i_ce)
		begin
			if (do_wr)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_rd)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_data_reg <= mem[rd_ptr_reg[AW-1:0]];
				out_valid_reg <= 1'b1;
			end
			else if (i_ready)
				out_valid_reg <= 1'b0;
		end
	end

endmodule // sdd_fifo

// file: sdd_port_model.sv
`timescale 1ns/100ps
module sdd_port_model (
	input wire logic i_clk,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire sdd_pkg::sdd_sample_s i_sample,
	output logic o_ready
);
	sdd_pkg::sdd_sample_s got [$];
	initial o_ready = 1'b0;
	// Ready moves only at the falling edge
	always @(negedge i_clk)
		o_ready <= !i_stall;
	always @(posedge i_clk)
		if (i_valid === 1'b1 && o_ready)
			got.push_back(i_sample);
endmodule // sdd_port_model

// file: sigma_delta_decimation_channel_bench.sv
`timescale 1ns/100ps
module sigma_delta_decimation_channel_bench;
	localparam logic [15:0] EXD [6] = '{16'h7FFF, 16'h8000, 16'h4000, 16'hC000, 16'h0000, 16'h0000};
	localparam logic [15:0] EXM [6] = '{16'h3FFF, 16'h4000, 16'h2000, 16'h6000, 16'h0000, 16'h0000};
	localparam logic [5:0] DB [8] = '{6'h00, 6'h06, 6'h0C, 6'h12, 6'h14, 6'h1A, 6'h20, 6'h26};
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] div = 3'h0;
	logic dsel = 1'b1;
	logic msel = 1'b0;
	logic stall = 1'b0;
	logic ce = 1'b1;
	logic [sdd_pkg::NCH-1:0][2:0] gsel = '0;
	logic [sdd_pkg::NCH-1:0] mbit;
	logic [sdd_pkg::NCH-1:0][5:0] gdb;
	logic strobe, ev, ovr, vld, rdy;
	sdd_pkg::sdd_sample_s smp;
	logic [3:0] pat [6] = '{4'hF, 4'h0, 4'hE, 4'h8, 4'hA, 4'hC};
	logic [1:0] ph = 2'h0;
	int num_errors = 0;
	int check_count = 0;
	always #12.5 i_clk = ~i_clk;
	// Periodic bitstreams, one bit per modulator strobe
	always @(negedge i_clk)
		if (strobe === 1'b1)
			ph <= ph + 2'h1;
	always_comb
		for (int c = 0; c < 6; c++)
			mbit[c] = pat[c][ph];
	sdd_decim_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_mclk_div_code(div),
		.i_cfg_data_sel(dsel), .i_cfg_mixed_sel(msel), .i_gain_sel(gsel), .i_mod_bit(mbit),
		.o_mod_strobe(strobe), .o_gain_db(gdb), .o_sample_event(ev), .o_overrun(ovr),
		.o_sample_valid(vld), .i_sample_ready(rdy), .o_sample(smp));
	sdd_port_model u_port (.i_clk(i_clk), .i_stall(stall), .i_valid(vld), .i_sample(smp),
		.o_ready(rdy));
	task automatic print_verdict();
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string name, input logic [18:0] ex, input logic [18:0] got);
		check_count++;
		if (got !== ex)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, ex, got);
		end
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? ev : s == 1 ? strobe : s == 2 ? vld : ovr;
	endfunction
	task automatic wait_hi(input int s, input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge i_clk);
			n++;
		end
		while (pick(s) !== 1'b1 && n < lim);
		if (pick(s) !== 1'b1)
		begin
			cmp("timeout", 19'h1, 19'h0);
			print_verdict();
		end
	endtask
	task automatic chk_period(input logic [15:0] ex [6]);
		int n;
		wait_hi(0, 600, n);
		u_port.got.delete();
		wait_hi(2, 8, n);
		cmp("latency", 19'h2, 19'(n));
		repeat (12) @(negedge i_clk);
		cmp("count", 19'h6, 19'(u_port.got.size()));
		foreach (u_port.got[k])
			cmp("word", {3'(k), ex[k]}, u_port.got[k]);
	endtask
	task automatic t_gain();
		for (int g = 0; g < 8; g++)
		begin
			for (int c = 0; c < 6; c++)
				gsel[c] = 3'((g + c) % 8);
			repeat (2) @(negedge i_clk);
			for (int c = 0; c < 6; c++)
				cmp("gain", 19'(DB[(g + c) % 8]), 19'(gdb[c]));
		end
	endtask
	task automatic t_rates();
		int codes [4] = '{1, 4, 5, 0};
		int n, r;
		foreach (codes[i])
		begin
			div = 3'(codes[i]);
			r = codes[i] <= 4 ? codes[i] + 1 : 1;
			wait_hi(0, 2000, n);
			wait_hi(0, 1400, n);
			cmp("event gap", 19'(256 * r), 19'(n));
			wait_hi(1, 50, n);
			wait_hi(1, 50, n);
			cmp("bit gap", 19'(8 * r), 19'(n));
		end
	endtask
	task automatic t_conv();
		int n;
		repeat (3) wait_hi(0, 600, n);
		chk_period(EXD);
		msel = 1'b1;
		wait_hi(0, 600, n);
		chk_period(EXM);
	endtask
	task automatic t_ctrl();
		int n;
		dsel = 1'b0;
		repeat (2) wait_hi(0, 600, n);
		u_port.got.delete();
		wait_hi(0, 600, n);
		repeat (12) @(negedge i_clk);
		cmp("ctrl words", 19'h0, 19'(u_port.got.size()));
		dsel = 1'b1;
	endtask
	task automatic t_ovr();
		int n;
		stall = 1'b1;
		wait_hi(3, 1200, n);
		cmp("held valid", 19'h1, 19'(vld));
		stall = 1'b0;
		chk_period(EXM);
	endtask
	task automatic t_ce();
		int n;
		wait_hi(0, 600, n);
		ce = 1'b0;
		repeat (100) @(negedge i_clk);
		cmp("frozen event", 19'h1, 19'(ev));
		cmp("frozen strobe", 19'h1, 19'(strobe));
		ce = 1'b1;
		wait_hi(0, 600, n);
		cmp("resumed gap", 19'h100, 19'(n));
	endtask
	initial
	begin
		repeat (20) @(negedge i_clk);
		i_rst = 1'b0;
		cmp("rst gain", 19'h1, 19'(gdb == '0));
		cmp("rst valid", 19'h0, 19'(vld));
		t_gain();
		t_rates();
		t_conv();
		t_ctrl();
		t_ovr();
		t_ce();
		print_verdict();
	end
endmodule // sigma_delta_decimation_channel_bench
